// >>> rtl/hub_regs_pkg.sv
// Purpose: Shared constants and types of the hub control register logic
// Assumes: Registers are 8 bits wide and reached over the local I2C target
// Notes:   Offsets are register indices as seen by the I2C pointer byte
package hub_regs_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] REG_LOCAL_ID     = 8'h00;
  localparam logic [7:0] REG_GEN_STATUS   = 8'h04;
  localparam logic [7:0] REG_PORT_SEL     = 8'h4C;
  localparam logic [7:0] REG_CC_CONFIG    = 8'h58;
  localparam logic [7:0] REG_REMOTE_ALIAS = 8'h5C;

  // ==========================================================================
  // Field positions
  localparam int PSEL_RD_BIT      = 4;  // Read port select
  localparam int PSEL_PORTNUM_BIT = 5;  // Physical port number readback
  localparam int CC_PASS_BIT      = 6;  // Passthrough by alias
  localparam int CC_PASS_ALL_BIT  = 7;  // Passthrough all (stored only)
  localparam int ALIAS_AUTOACK    = 0;  // Auto acknowledge of writes
  localparam int STS_CKSUM_BIT    = 7;
  localparam int STS_INIT_BIT     = 6;
  localparam int STS_REFCLK_BIT   = 3;
  localparam int STS_LOCK_BIT     = 2;
  localparam int STS_PASS_BIT     = 1;
  localparam int STS_CLKDET_BIT   = 0;

  // ==========================================================================
  // Values after reset and strap decode
  localparam logic [7:0] PORT_SEL_RST   = 8'h01;
  localparam logic [7:0] CC_CONFIG_RST  = 8'h00;
  localparam logic [7:0] ALIAS_RST      = 8'h00;
  localparam logic [6:0] ADDR_BASE_DEF  = 7'h30;
  localparam logic [6:0] ADDR_BASE_MAX  = 7'h74;
  localparam int         STRAP_W        = 2;
  localparam int         NUM_PORTS      = 2;
  localparam int         RAW_STS_W      = 7;

  // ==========================================================================
  // Forward request kinds and controller states
  typedef enum logic [1:0] {
    FWD_ADDR  = 2'h0,
    FWD_WRITE = 2'h1,
    FWD_READ  = 2'h2,
    FWD_STOP  = 2'h3
  } fwd_kind_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_ADDR = 4'h1,
    S_PTR  = 4'h3,
    S_WR   = 4'h2,
    S_RD   = 4'h6,
    S_FW   = 4'h7,
    S_FR   = 4'h5
  } hub_state_t;

endpackage : hub_regs_pkg

// >>> rtl/i2c_target_phy.sv
// Purpose: Bit level I2C target front end: sync, start/stop, byte shifter
// Assumes: Pins sampled by CLK_SYS; SCL high and low phases last >= 4 clocks
// Notes:   Drives SDA and SCL low only; stretch holds SCL low while asked
module i2c_target_phy
  import hub_regs_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // Pin samples and drives
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            scl_oe,
  output logic            sda_oe,
  // Controls from the register logic
  input  wire logic       tx_mode,
  input  wire logic       ack_en,
  input  wire logic [7:0] tx_byte,
  input  wire logic       stretch,
  // Events and received data
  output logic            start_p,
  output logic            stop_p,
  output logic            byte_p,
  output logic            ack_p,
  output logic            master_ack,
  output logic [7:0]      rx_byte
);

  typedef struct packed {
    logic [1:0] scl_sy;
    logic [1:0] sda_sy;
    logic       scl_p;
    logic       sda_p;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic       sda_oe;
    logic       scl_oe;
    logic       start;
    logic       stop;
    logic       byte_p;
    logic       ack_p;
    logic       mack;
  } phy_t;

  phy_t st_q;
  phy_t st_d;
  logic scl;
  logic sda;

  // ==========================================================================
  // Line sampling, framing and bit handling
  assign scl = st_q.scl_sy[1];
  assign sda = st_q.sda_sy[1];

  // One pass per clock: conditions first, then the low phase drive
  always_comb
  begin
    st_d        = st_q;
    st_d.start  = 1'b0;
    st_d.stop   = 1'b0;
    st_d.byte_p = 1'b0;
    st_d.ack_p  = 1'b0;
    st_d.scl_sy = {st_q.scl_sy[0], scl_in};
    st_d.sda_sy = {st_q.sda_sy[0], sda_in};
    st_d.scl_p  = scl;
    st_d.sda_p  = sda;
    // Stretch only begins in a low phase so no false edge is made
    st_d.scl_oe = stretch & (~scl | st_q.scl_oe);
    if (scl && st_q.scl_p && st_q.sda_p && !sda)
    begin
      st_d.start  = 1'b1;
      st_d.cnt    = 4'h0;
      st_d.sda_oe = 1'b0;
    end
    else if (scl && st_q.scl_p && !st_q.sda_p && sda)
    begin
      st_d.stop   = 1'b1;
      st_d.cnt    = 4'h0;
      st_d.sda_oe = 1'b0;
    end
    else if (scl && !st_q.scl_p)
    begin
      if (st_q.cnt < 4'h8)
      begin
        st_d.sh     = {st_q.sh[6:0], sda};
        st_d.cnt    = st_q.cnt + 4'h1;
        st_d.byte_p = (st_q.cnt == 4'h7);
      end
      else if (st_q.cnt == 4'h8)
      begin
        st_d.cnt   = 4'h9;
        st_d.ack_p = 1'b1;
        st_d.mack  = ~sda;  // Master ack is SDA low
      end
    end
    else if (!scl)
    begin
      // Data is set up in the low phase and held while SCL is high
      if (st_q.cnt == 4'h8)
        st_d.sda_oe = ack_en & ~tx_mode;
      else if (st_q.cnt == 4'h9 || st_q.cnt == 4'h0)
      begin
        st_d.cnt    = 4'h0;
        st_d.tx     = tx_byte;
        st_d.sda_oe = tx_mode & ~tx_byte[7];
      end
      else
        st_d.sda_oe = tx_mode & ~st_q.tx[3'(4'h7 - st_q.cnt)];
    end
    if (sys_rst)
    begin
      st_d.cnt    = 4'h0;
      st_d.sda_oe = 1'b0;
      st_d.scl_oe = 1'b0;
      st_d.scl_p  = 1'b1;
      st_d.sda_p  = 1'b1;
      st_d.sh     = 8'h00;
      st_d.tx     = 8'h00;
      st_d.mack   = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk_sys)
  begin
    st_q <= st_d;
  end

  assign scl_oe     = st_q.scl_oe;
  assign sda_oe     = st_q.sda_oe;
  assign start_p    = st_q.start;
  assign stop_p     = st_q.stop;
  assign byte_p     = st_q.byte_p;
  assign ack_p      = st_q.ack_p;
  assign master_ack = st_q.mack;
  assign rx_byte    = st_q.sh;

endmodule : i2c_target_phy

// >>> rtl/hub_ctrl_regs.sv
// Purpose: I2C reachable control registers of a two port link hub
// Assumes: Forward channel logic shares CLK_SYS; status inputs are async
// Notes:   Alias traffic is forwarded byte by byte; SCL is stretched for each byte except auto-ack writes

module hub_ctrl_regs
  #(parameter logic [6:0] ADDR_BASE = hub_regs_pkg::ADDR_BASE_DEF)
(
  // System
  input  wire logic                       CLK_SYS,
  input  wire logic                       SYS_RST,
  // I2C pins, open drain
  input  wire logic                       SCL_IN,
  output logic                            SCL_OUT,
  output logic                            SCL_OE,
  input  wire logic                       SDA_IN,
  output logic                            SDA_OUT,
  output logic                            SDA_OE,
  // Address strap
  input  wire logic [1:0]                 ADDRESS_STRAP_PIN,
  // Raw link status
  input  wire logic                       CKSUM_CFG,
  input  wire logic                       INIT_DONE,
  input  wire logic                       REFCLK_VALID,
  input  wire logic                       PLL_LOCKED,
  input  wire logic                       DATA_VALID,
  input  wire logic                       LINK_PASS,
  input  wire logic                       CLK_DETECT,
  // Bidirectional control channel requests
  output logic                            FWD_REQ,
  output hub_regs_pkg::fwd_kind_t         FWD_KIND,
  output logic [7:0]                      FWD_DATA,
  output logic [1:0]                      FWD_PORTS,
  input  wire logic                       FWD_DONE,
  input  wire logic                       FWD_NACK,
  input  wire logic [7:0]                 FWD_RDATA
);
  import hub_regs_pkg::*;

  // ==========================================================================
  // State
  typedef struct packed {
    hub_state_t                        st;
    logic [7:0]                        ptr;
    logic                              rd_sel;
    logic [1:0]                        wr_en;
    logic [7:0]                        cc_cfg;
    logic [NUM_PORTS-1:0][7:0]         alias_r;
    logic [6:0]                        own_addr;
    logic [1:0][STRAP_W-1:0]           strap_sy;
    logic [RAW_STS_W-1:0]              sts0;
    logic [RAW_STS_W-1:0]              sts1;
    logic                              ack_en;
    logic                              tx_mode;
    logic [7:0]                        tx_byte;
    logic                              pend;
    logic                              pend_d;
    logic [1:0]                        tgt;
    logic                              fwd_req;
    fwd_kind_t                         fwd_kind;
    logic [7:0]                        fwd_data;
  } hub_t;

  hub_t                  st_q;
  hub_t                  st_d;
  logic                  start_p;
  logic                  stop_p;
  logic                  byte_p;
  logic                  ack_p;
  logic                  mack;
  logic [7:0]            rx;
  logic                  scl_oe_w;
  logic                  sda_oe_w;
  logic [NUM_PORTS-1:0]  match;
  logic [1:0]            tgt_r;
  logic [1:0]            tgt_w;
  logic                  passthru;
  logic                  auto_ack;
  logic                  ack_port;
  logic                  lock_now;
  logic [7:0]            status_img;
  logic [7:0]            sel_alias;

  // ==========================================================================
  // Elaboration check: the strap offsets must stay in the 7-bit space
  if (ADDR_BASE > ADDR_BASE_MAX)
  begin : g_bad_base
    $error("ADDR_BASE leaves no room for strap offsets");
  end

  // ==========================================================================
  // Pin front end
  i2c_target_phy u_phy (
    .clk_sys    (CLK_SYS),
    .sys_rst    (SYS_RST),
    .scl_in     (SCL_IN),
    .sda_in     (SDA_IN),
    .scl_oe     (scl_oe_w),
    .sda_oe     (sda_oe_w),
    .tx_mode    (st_q.tx_mode),
    .ack_en     (st_q.ack_en),
    .tx_byte    (st_q.tx_byte),
    .stretch    (st_q.pend | st_q.pend_d),
    .start_p    (start_p),
    .stop_p     (stop_p),
    .byte_p     (byte_p),
    .ack_p      (ack_p),
    .master_ack (mack),
    .rx_byte    (rx)
  );

  // ==========================================================================
  // Alias decode, one comparator per port copy
  for (genvar p = 0; p < NUM_PORTS; p++)
  begin : g_match
    assign match[p] = (st_q.alias_r[p][7:1] == rx[7:1]);
  end

  assign passthru  = st_q.cc_cfg[CC_PASS_BIT];
  assign tgt_r     = match[0] ? 2'b01 : 2'b10;
  // Broadcast only when both copies match and both may be written
  assign tgt_w     = (&match && &st_q.wr_en) ? 2'b11 : tgt_r;
  // Data bytes are no addresses; in the data phase the latched target decides
  assign ack_port  = (st_q.st == S_FW) ? st_q.tgt[0] : tgt_r[0];
  assign auto_ack  = ack_port ? st_q.alias_r[0][ALIAS_AUTOACK]
                              : st_q.alias_r[1][ALIAS_AUTOACK];
  assign sel_alias = st_q.alias_r[st_q.rd_sel];
  assign lock_now  = st_q.sts1[3] & st_q.sts1[2];

  // Status image; a fully healthy link reads back 0xCF
  always_comb
  begin
    status_img                 = 8'h00;
    status_img[STS_CKSUM_BIT]  = st_q.sts1[6];
    status_img[STS_INIT_BIT]   = st_q.sts1[5];
    status_img[STS_REFCLK_BIT] = st_q.sts1[4];
    status_img[STS_LOCK_BIT]   = lock_now;
    status_img[STS_PASS_BIT]   = st_q.sts1[1];
    status_img[STS_CLKDET_BIT] = st_q.sts1[0];
  end

  // Read mux; unmapped offsets read as zero
  function automatic logic [7:0] reg_val(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      REG_LOCAL_ID:     v = {st_q.own_addr, 1'b0};
      REG_GEN_STATUS:   v = status_img;
      REG_PORT_SEL:
      begin
        v[PSEL_PORTNUM_BIT] = st_q.rd_sel;
        v[PSEL_RD_BIT]      = st_q.rd_sel;
        v[1:0]              = st_q.wr_en;
      end
      REG_CC_CONFIG:    v = st_q.cc_cfg;
      REG_REMOTE_ALIAS: v = sel_alias;
      default:          v = 8'h00;
    endcase
    return v;
  endfunction : reg_val

  // ==========================================================================
  // Transaction controller
  always_comb
  begin
    st_d          = st_q;
    st_d.fwd_req  = 1'b0;
    st_d.pend_d   = st_q.pend;
    st_d.strap_sy = {st_q.strap_sy[0], ADDRESS_STRAP_PIN};
    st_d.sts0     = {CKSUM_CFG, INIT_DONE, REFCLK_VALID, PLL_LOCKED,
                     DATA_VALID, LINK_PASS, CLK_DETECT};
    st_d.sts1     = st_q.sts0;
    // Channel answer ends the stretch
    if (st_q.pend && FWD_DONE)
    begin
      st_d.pend = 1'b0;
      if (st_q.fwd_kind == FWD_READ)
        st_d.tx_byte = FWD_RDATA;
      else
        st_d.ack_en = ~FWD_NACK;
    end
    if (start_p)
    begin
      st_d.st      = S_ADDR;
      st_d.ack_en  = 1'b0;
      st_d.tx_mode = 1'b0;
      st_d.pend    = 1'b0;
    end
    else if (stop_p)
    begin
      // A stop closes the remote transaction as well
      if (st_q.st == S_FW || st_q.st == S_FR)
      begin
        st_d.fwd_req  = 1'b1;
        st_d.fwd_kind = FWD_STOP;
      end
      st_d.st      = S_IDLE;
      st_d.ack_en  = 1'b0;
      st_d.tx_mode = 1'b0;
      st_d.pend    = 1'b0;
    end
    else if (byte_p)
    begin
      unique case (st_q.st)
        S_ADDR:
        begin
          if (rx[7:1] == st_q.own_addr)
          begin
            st_d.ack_en = 1'b1;
            st_d.st     = rx[0] ? S_RD : S_PTR;
          end
          else if (passthru && |match)
          begin
            st_d.tgt      = rx[0] ? tgt_r : tgt_w;
            st_d.st       = rx[0] ? S_FR : S_FW;
            st_d.fwd_req  = 1'b1;
            st_d.fwd_kind = FWD_ADDR;
            st_d.fwd_data = rx;
            st_d.ack_en   = ~rx[0] & auto_ack;
            st_d.pend     = rx[0] | ~auto_ack;
          end
          else
          begin
            st_d.ack_en = 1'b0;
            st_d.st     = S_IDLE;
          end
        end
        S_PTR:
        begin
          st_d.ptr = rx;
          st_d.st  = S_WR;
        end
        S_WR:
        begin
          case (st_q.ptr)
            REG_PORT_SEL:
            begin
              st_d.rd_sel = rx[PSEL_RD_BIT];
              st_d.wr_en  = rx[1:0];
            end
            REG_CC_CONFIG:    st_d.cc_cfg = rx;
            REG_REMOTE_ALIAS:
            begin
              for (int p = 0; p < NUM_PORTS; p++)
                if (st_q.wr_en[p])
                  st_d.alias_r[p] = rx;
            end
            default:          st_d.ptr = st_q.ptr;
          endcase
          st_d.ptr = st_q.ptr + 8'h01;
        end
        S_FW:
        begin
          // Auto-ack writes go out without waiting for the far end
          st_d.fwd_req  = 1'b1;
          st_d.fwd_kind = FWD_WRITE;
          st_d.fwd_data = rx;
          st_d.ack_en   = auto_ack;
          st_d.pend     = ~auto_ack;
        end
        S_IDLE, S_RD, S_FR:
          st_d.ack_en = st_q.ack_en;
        default:
          st_d.st = S_IDLE;
      endcase
    end
    else if (ack_p)
    begin
      if (st_q.st == S_RD)
      begin
        if (!st_q.tx_mode)
        begin
          st_d.tx_mode = st_q.ack_en;
          st_d.tx_byte = reg_val(st_q.ptr);
        end
        else if (mack)
        begin
          st_d.ptr     = st_q.ptr + 8'h01;
          st_d.tx_byte = reg_val(st_q.ptr + 8'h01);
        end
        else
        begin
          st_d.tx_mode = 1'b0;
          st_d.st      = S_IDLE;
        end
      end
      else if (st_q.st == S_FR)
      begin
        if ((!st_q.tx_mode && st_q.ack_en) || (st_q.tx_mode && mack))
        begin
          st_d.tx_mode  = 1'b1;
          st_d.fwd_req  = 1'b1;
          st_d.fwd_kind = FWD_READ;
          st_d.pend     = 1'b1;
        end
        else
        begin
          // Stay in the forward state so the I2C stop reaches the remote
          st_d.tx_mode = 1'b0;
        end
      end
    end
    if (SYS_RST)
    begin
      st_d.st       = S_IDLE;
      st_d.ptr      = 8'h00;
      st_d.rd_sel   = PORT_SEL_RST[PSEL_RD_BIT];
      st_d.wr_en    = PORT_SEL_RST[1:0];
      st_d.cc_cfg   = CC_CONFIG_RST;
      st_d.alias_r  = {NUM_PORTS{ALIAS_RST}};
      // Strap is caught from the synchroniser while reset is held
      st_d.own_addr = ADDR_BASE + {5'b00000, st_q.strap_sy[1]};
      st_d.ack_en   = 1'b0;
      st_d.tx_mode  = 1'b0;
      st_d.tx_byte  = 8'h00;
      st_d.pend     = 1'b0;
      st_d.pend_d   = 1'b0;
      st_d.tgt      = 2'b00;
      st_d.fwd_req  = 1'b0;
      st_d.fwd_kind = FWD_ADDR;
      st_d.fwd_data = 8'h00;
    end
  end

  // State register
  always_ff @(posedge CLK_SYS)
  begin
    st_q <= st_d;
  end

  // ==========================================================================
  // Outputs; open drain lines only ever pull low
  assign SCL_OUT   = 1'b0;
  assign SDA_OUT   = 1'b0;
  assign SCL_OE    = scl_oe_w;
  assign SDA_OE    = sda_oe_w;
  assign FWD_REQ   = st_q.fwd_req;
  assign FWD_KIND  = st_q.fwd_kind;
  assign FWD_DATA  = st_q.fwd_data;
  assign FWD_PORTS = st_q.tgt;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);

  a_id_local: assert property (
    (st_q.st == S_RD && ack_p && !st_q.tx_mode && st_q.ack_en
     && st_q.ptr == REG_LOCAL_ID)
    |=> st_q.tx_byte == {st_q.own_addr, 1'b0} && !FWD_REQ)
    else $error("local identity not served");

  a_own_addr: assert property (
    (st_q.st == S_ADDR && byte_p && !start_p && !stop_p
     && rx[7:1] == st_q.own_addr) |=> st_q.ack_en && !FWD_REQ)
    else $error("own address not acknowledged");

  a_lock_bit: assert property (
    (st_q.st == S_RD && ack_p && !st_q.tx_mode && st_q.ack_en
     && st_q.ptr == REG_GEN_STATUS)
    |=> st_q.tx_byte[STS_LOCK_BIT] == $past(lock_now))
    else $error("lock bit mismatch");

  a_healthy: assert property (
    (&st_q.sts1) |-> status_img == 8'hCF)
    else $error("healthy link not 0xCF");

  a_auto_ack: assert property (
    (st_q.st == S_FW && byte_p && !start_p && !stop_p && auto_ack)
    |=> FWD_REQ && FWD_KIND == FWD_WRITE && st_q.ack_en && !st_q.pend)
    else $error("auto ack write not forwarded");

  a_read_fwd: assert property (
    (st_q.st == S_FR && ack_p && !start_p && !stop_p
     && (st_q.tx_mode ? mack : st_q.ack_en))
    |=> FWD_REQ && FWD_KIND == FWD_READ && st_q.pend)
    else $error("alias read not forwarded");

  a_pass_gate: assert property (
    (st_q.st == S_ADDR && byte_p && !start_p && !stop_p && !passthru
     && rx[7:1] != st_q.own_addr) |=> !FWD_REQ && st_q.st == S_IDLE)
    else $error("alias mapped without passthrough");

  a_port_read: assert property (
    (st_q.st == S_RD && ack_p && !st_q.tx_mode && st_q.ack_en
     && st_q.ptr == REG_REMOTE_ALIAS)
    |=> st_q.tx_byte == $past(sel_alias))
    else $error("read port copy mismatch");

  a_copy_hold: assert property (
    (st_q.st == S_WR && byte_p && !start_p && !stop_p
     && st_q.ptr == REG_REMOTE_ALIAS && !st_q.wr_en[0])
    |=> $stable(st_q.alias_r[0]))
    else $error("disabled copy changed");

  a_copy_write: assert property (
    (st_q.st == S_WR && byte_p && !start_p && !stop_p
     && st_q.ptr == REG_REMOTE_ALIAS && st_q.wr_en[1])
    |=> st_q.alias_r[1] == $past(rx))
    else $error("enabled copy not written");

  a_broadcast: assert property (
    (st_q.st == S_ADDR && byte_p && !start_p && !stop_p && passthru
     && rx[7:1] != st_q.own_addr && &match && &st_q.wr_en && !rx[0])
    |=> FWD_PORTS == 2'b11)
    else $error("broadcast not to both ports");

endmodule : hub_ctrl_regs

// >>> tb/remote_peer.sv
// Purpose: Remote serializer answering on the control channel
// Assumes: The hub keeps one request outstanding at a time
// Notes:   Idle nack and rdata lines churn so stale values never pass
module remote_peer
(
  // System
  input  wire logic       clk,
  input  wire logic       rst,
  // Requests and commanded refusal
  input  wire logic       req,
  input  wire logic [7:0] id,
  input  wire logic       nack_cmd,
  // Answers
  output logic            done,
  output logic            nack,
  output logic [7:0]      rdata
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========
  // Answer delay
  logic [5:0] cnt_q;

  // Delay of 2 or 34 cycles, picked by the churning data bit
  always_ff @(posedge clk)
  begin
    done  <= 1'h0;
    nack  <= ~nack;
    rdata <= ~rdata;
    if (rst)
    begin
      cnt_q <= 6'h00;
      rdata <= 8'h00;
      nack  <= 1'h0;
    end
    else if (req)
      cnt_q <= {rdata[0], 5'h02};
    else if (cnt_q != 6'h00)
      cnt_q <= cnt_q - 6'h01;
    if (!rst && cnt_q == 6'h01)
    begin
      done  <= 1'h1;
      nack  <= nack_cmd;  // Refuses only on command
      rdata <= id;        // Identity at offset zero
    end
  end
endmodule : remote_peer

// >>> tb/testbench.sv
// Purpose: Self-checking bench of the hub control registers
// Assumes: Bench is the I2C master, SCL period 160 ns
// Notes:   Lines are wired-AND with pull-ups
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import hub_regs_pkg::*;

  // ==========
  // Bench state
  logic       clk = 1'h0, rst = 1'h1, scl_m = 1'h1, sda_m = 1'h1;
  logic       nack_cmd = 1'h0, ak, req, done, nack, scl_oe, sda_oe;
  logic [1:0] strap, ports, seen, lo;
  logic [6:0] sts = 7'h00, own, a0, a1;
  logic [7:0] lfsr = 8'h4A, v, rid = 8'h00, rdata, fdata, fdat;
  fwd_kind_t  kind;
  int         n_mismatch = 0, tests_run = 0, cycles = 0;
  wire        scl = scl_m & (~scl_oe | lo[1]);
  wire        sda = sda_m & (~sda_oe | lo[0]);

  hub_ctrl_regs u_dut
  (
    .CLK_SYS(clk), .SYS_RST(rst), .SCL_IN(scl), .SCL_OUT(lo[1]),
    .SCL_OE(scl_oe), .SDA_IN(sda), .SDA_OUT(lo[0]), .SDA_OE(sda_oe),
    .ADDRESS_STRAP_PIN(strap), .CKSUM_CFG(sts[6]), .INIT_DONE(sts[5]),
    .REFCLK_VALID(sts[4]), .PLL_LOCKED(sts[3]), .DATA_VALID(sts[2]),
    .LINK_PASS(sts[1]), .CLK_DETECT(sts[0]), .FWD_REQ(req),
    .FWD_KIND(kind), .FWD_DATA(fdata), .FWD_PORTS(ports), .FWD_DONE(done),
    .FWD_NACK(nack), .FWD_RDATA(rdata)
  );
  remote_peer u_peer
  (
    .clk(clk), .rst(rst), .req(req), .id(rid), .nack_cmd(nack_cmd),
    .done(done), .nack(nack), .rdata(rdata)
  );

  // System clock
  always #10 clk = ~clk;
  // Port mask capture and hang limit
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (req && kind == FWD_ADDR)
    begin
      seen <= ports;
      fdat <= fdata;
    end
    if (cycles == 40000)
    begin
      n_mismatch++;
      summarize();
    end
  end

  // ==========
  // Helpers
  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : nxt
  function automatic logic [7:0] sexp(input logic [6:0] s);
    return {s[6:5], 2'h0, s[4], s[3] & s[2], s[1:0]};
  endfunction : sexp
  task automatic summarize();
    if (n_mismatch == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  task automatic check(input string what, input logic [7:0] got, exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // One bit; waits out clock stretching before the high phase
  task automatic bitx(input logic b, output logic r);
    sda_m <= b;
    cyc(2);
    scl_m <= 1'h1;
    cyc(1);
    while (scl !== 1'h1) cyc(1);
    cyc(2);
    @(negedge clk) r = sda;
    @(posedge clk) scl_m <= 1'h0;
    cyc(2);
  endtask : bitx
  task automatic xfer(input logic [7:0] d, input logic m,
                      output logic [7:0] r);
    for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
    bitx(m, ak);
  endtask : xfer
  // Start when s0 high and s1 low, stop the other way round
  task automatic cond(input logic s0, s1);
    sda_m <= s0;
    cyc(4);
    scl_m <= 1'h1;
    cyc(4);
    sda_m <= s1;
    cyc(4);
    scl_m <= s1;
    cyc(2);
  endtask : cond
  task automatic wr(input logic [6:0] a, input logic [7:0] rg, d);
    cond(1'h1, 1'h0);
    xfer({a, 1'h0}, 1'h1, v);
    xfer(rg, 1'h1, v);
    xfer(d, 1'h1, v);
    cond(1'h0, 1'h1);
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] rg,
                    output logic [7:0] d);
    cond(1'h1, 1'h0);
    xfer({a, 1'h0}, 1'h1, v);
    xfer(rg, 1'h1, v);
    cond(1'h1, 1'h0);
    xfer({a, 1'h1}, 1'h1, v);
    xfer(8'hFF, 1'h1, d);
    cond(1'h0, 1'h1);
  endtask : rd

  // ==========
  // Main sequence
  initial
  begin
    strap = lfsr[1:0];
    own = ADDR_BASE_DEF + 7'(strap);
    cyc(10);
    rst <= 1'h0;
    cyc(4);
    rd(own, REG_LOCAL_ID, v);
    check("local id", v, {own, 1'h0});
    rd(own, REG_PORT_SEL, v);
    check("port sel reset", v, PORT_SEL_RST);
    for (int i = 0; i < 4; i++)
    begin
      sts <= (i == 0) ? 7'h7F : lfsr[6:0];
      lfsr = nxt(lfsr);
      rd(own, REG_GEN_STATUS, v);
      check("status", v, sexp(sts));
    end
    a0 = {2'h2, lfsr[4:0]};
    a1 = a0 ^ 7'h01;  // Distinct alias per port
    wr(own, REG_PORT_SEL, 8'h03);
    wr(own, REG_REMOTE_ALIAS, {a0, 1'h0});  // Shifted address
    wr(own, REG_PORT_SEL, 8'h01);
    wr(own, REG_REMOTE_ALIAS, {a1, 1'h0});
    rd(own, REG_REMOTE_ALIAS, v);
    check("alias p0", v, {a1, 1'h0});
    wr(own, REG_PORT_SEL, 8'h10);
    wr(own, REG_REMOTE_ALIAS, 8'hFE);
    rd(own, REG_REMOTE_ALIAS, v);
    check("alias p1", v, {a0, 1'h0});
    rd(own, REG_PORT_SEL, v);
    check("port sel", v, 8'h30);
    wr(own, REG_PORT_SEL, 8'h00);
    rd(own, REG_REMOTE_ALIAS, v);
    check("alias p0 kept", v, {a1, 1'h0});
    cond(1'h1, 1'h0);
    xfer({a1, 1'h1}, 1'h1, v);
    cond(1'h0, 1'h1);
    check("alias off", ak, 1'h1);
    wr(own, REG_CC_CONFIG, 8'h40);
    rd(own, REG_CC_CONFIG, v);
    check("pass cfg", v, 8'h40);
    rid <= lfsr;
    rd(a1, 8'h00, v);
    check("remote id", v, rid);
    wr(own, REG_PORT_SEL, 8'h01);
    wr(own, REG_REMOTE_ALIAS, {a1, 1'h1});
    nack_cmd <= 1'h1;
    wr(a1, 8'h10, lfsr);
    check("auto ack", ak, 1'h0);
    wr(own, REG_REMOTE_ALIAS, {a1, 1'h0});
    cond(1'h1, 1'h0);
    xfer({a1, 1'h0}, 1'h1, v);
    check("remote nack", ak, 1'h1);
    cond(1'h0, 1'h1);
    nack_cmd <= 1'h0;
    wr(own, REG_PORT_SEL, 8'h03);
    wr(own, REG_REMOTE_ALIAS, {a0, 1'h0});
    wr(a0, 8'h20, lfsr);
    check("broadcast", {6'h00, seen}, 8'h03);
    check("fwd address", fdat, {a0, 1'h0});
    check("pin level", {6'h00, lo}, 8'h00);
    summarize();
  end
endmodule : testbench
